// File: hdl/frame_addr_pkg.sv
// constants and carrier types for the rotated frame address controller
// assumes one 25 MHz clock domain and a device register port of word writes
package frame_addr_pkg;

  // software-side register offsets
  localparam logic [7:0] SW_CTRL = 8'h00;
  localparam logic [7:0] SW_PANEL = 8'h04;
  localparam logic [7:0] SW_FORMAT = 8'h08;
  localparam logic [7:0] SW_CORNER = 8'h0C;
  localparam logic [7:0] SW_STATUS = 8'h10;
  localparam logic [7:0] SW_START_RES = 8'h14;
  localparam logic [7:0] SW_STRIDE_RES = 8'h18;

  // device register offsets
  localparam logic [7:0] DEV_SETTINGS = 8'h10;
  localparam logic [7:0] DEV_START = 8'h40;
  localparam logic [7:0] DEV_STRIDE = 8'h44;

  // field positions and widths
  localparam int DIM_W = 10;
  localparam int HI_LSB = 16;
  localparam int ORI_LSB = 16;
  localparam int BPP_W = 5;
  localparam int START_W = 16;
  localparam int STRIDE_W = 10;
  localparam int MATH_W = 24;
  localparam int GO_BIT = 0;
  localparam int BUSY_BIT = 0;
  localparam int DONE_BIT = 1;
  localparam int ERR_BIT = 2;

  // arithmetic constants
  localparam logic [MATH_W-1:0] DWORD_BYTES = 24'h00_0004;
  localparam logic [MATH_W-1:0] PAD_MASK = 24'h00_0003;
  localparam logic [MATH_W-1:0] ONE = 24'h00_0001;
  localparam int BYTE_SHIFT = 3;
  localparam int WORD_BITS_LOG = 5;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    ORI_0 = 2'h0,
    ORI_90 = 2'h1,
    ORI_180 = 2'h2,
    ORI_270 = 2'h3
  } ori_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_MUL_CORNER = 3'h1,
    ST_MUL_FAR = 3'h3,
    ST_CALC = 3'h2,
    ST_WR_SET = 3'h6,
    ST_WR_START = 3'h7,
    ST_WR_OFS = 3'h5
  } ctl_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } sw_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [31:0] wdata;
  } dev_req_t;

endpackage

// File: hdl/seq_multiplier.sv
// shift-and-add multiplier, one multiplier bit per clock
// assumes start is a one-cycle pulse given only while idle
module seq_multiplier import frame_addr_pkg::*; #(
  parameter int A_W = 10,
  parameter int B_W = 12,
  parameter int P_W = A_W + B_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // operands
  input wire logic start,
  input wire logic [A_W-1:0] a,
  input wire logic [B_W-1:0] b,
  // result
  output logic done,
  output logic [P_W-1:0] product
);

  localparam int CNT_W = $clog2(A_W + 1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CNT_W-1:0] cnt;
    logic [P_W-1:0] acc;
    logic [P_W-1:0] mcand;
    logic [A_W-1:0] mplier;
  } mul_state_t;

  mul_state_t r_reg;
  mul_state_t r_next;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (start && !r_reg.busy) begin
      r_next.busy = 1'b1;
      r_next.cnt = CNT_W'(A_W);
      r_next.acc = '0;
      r_next.mcand = P_W'(b);
      r_next.mplier = a;
    end else if (r_reg.busy) begin
      if (r_reg.mplier[0]) begin
        r_next.acc = r_reg.acc + r_reg.mcand;
      end
      r_next.mcand = r_reg.mcand << 1;
      r_next.mplier = r_reg.mplier >> 1;
      r_next.cnt = r_reg.cnt - CNT_W'(1);
      if (r_reg.cnt == CNT_W'(1)) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done = r_reg.done;
  assign product = r_reg.acc;

endmodule

// File: hdl/frame_addr_ctrl.sv
// host controller that works out and programs the main window start
// word address and line word stride of a rotating display controller
// assumes the device takes word writes through a valid/ready port
//
// Overview of operation
// - The stride is the byte count of a line, width times bpp over 8, sent as word steps.
// - Image width is at least panel width for 0/180 and at least panel height for 90/270.
// - Image width is a multiple of 32 over bpp, otherwise a slightly wider one is chosen; this controller refuses go and sets err instead.
// - All fractions are truncated before any address or offset register is written.
// - The corner byte address is upper times stride plus left divided by bpp.
// - At 0 degrees the start address is the corner address divided by 4.
// - At 0 degrees the line offset is the width divided by 32 over bpp.
// - At 90 degrees the start is corner plus padded height bytes, over 4, minus 1.
// - At 180 degrees the start adds stride times height-1 and padded width bytes, over 4, less 1.
// - At 270 degrees stride uses height and start is corner plus (width-1) times stride, over 4.
// - At 90 and 270 degrees the line offset is the height divided by 32 over bpp.
// - The display buffer begins at word zero, so a zero corner is the usual case.
module frame_addr_ctrl import frame_addr_pkg::*; #(
  parameter int DIM_WIDTH = DIM_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // software register port
  input wire sw_req_t sw_req,
  output logic [31:0] sw_rdata,
  // device register port
  output dev_req_t dev_req,
  input wire logic dev_ready
);

  localparam int STRIDE_BITS = DIM_WIDTH + 2;

  typedef struct packed {
    ctl_state_t st;
    logic busy;
    logic done;
    logic err;
    logic [DIM_WIDTH-1:0] width;
    logic [DIM_WIDTH-1:0] height;
    logic [DIM_WIDTH-1:0] left;
    logic [DIM_WIDTH-1:0] upper;
    logic [BPP_W-1:0] bpp;
    ori_t ori;
    logic [2:0] bpp_log;
    logic [STRIDE_BITS-1:0] stride;
    logic [MATH_W-1:0] corner;
    logic [MATH_W-1:0] far;
    logic [START_W-1:0] start_addr;
    logic [STRIDE_W-1:0] line_words;
    logic mul_go;
    logic [DIM_WIDTH-1:0] mul_a;
    logic [31:0] rdata;
    dev_req_t dev;
  } ctl_t;

  ctl_t r_reg;
  ctl_t r_next;
  logic mul_done;
  logic [DIM_WIDTH+STRIDE_BITS-1:0] mul_p;

  // byte count of a run of pixels, truncated
  function automatic logic [MATH_W-1:0] bytes_of(input logic [DIM_WIDTH-1:0] pix,
                                                 input logic [2:0] lg);
    logic [MATH_W-1:0] bits;
    bits = MATH_W'(pix) << lg;
    return bits >> BYTE_SHIFT;
  endfunction

  // bytes that pad a byte count up to the next dword
  function automatic logic [MATH_W-1:0] pad_of(input logic [MATH_W-1:0] b);
    return (DWORD_BYTES - b) & PAD_MASK;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  seq_multiplier #(
    .A_W(DIM_WIDTH),
    .B_W(STRIDE_BITS),
    .P_W(DIM_WIDTH + STRIDE_BITS)
  ) u_mul (
    .clk(clk),
    .rst(rst),
    .start(r_reg.mul_go),
    .a(r_reg.mul_a),
    .b(r_reg.stride),
    .done(mul_done),
    .product(mul_p)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [2:0] lg;
    logic lg_ok;
    logic [MATH_W-1:0] hb;
    logic [MATH_W-1:0] wb;
    logic [MATH_W-1:0] sum;
    logic [DIM_WIDTH-1:0] line_pix;
    logic dim_ok;
    logic [DIM_WIDTH-1:0] line_dim;
    logic [DIM_WIDTH-1:0] align_mask;
    lg = 3'h0;
    lg_ok = 1'b1;
    hb = '0;
    wb = '0;
    sum = '0;
    line_pix = '0;
    dim_ok = 1'b1;
    line_dim = '0;
    align_mask = '0;
    r_next = r_reg;
    r_next.mul_go = 1'b0;
    r_next.rdata = RESET_WORD;

    case (r_reg.bpp)
      5'h01: lg = 3'h0;
      5'h02: lg = 3'h1;
      5'h04: lg = 3'h2;
      5'h08: lg = 3'h3;
      5'h10: lg = 3'h4;
      default: lg_ok = 1'b0;
    endcase

    // refuse a line that is empty or ends in part of a word
    // a zero dimension would also wrap the minus-one terms to the far end
    if (r_reg.ori == ORI_0 || r_reg.ori == ORI_180) begin
      line_dim = r_reg.width;
    end else begin
      line_dim = r_reg.height;
    end
    align_mask = ~({DIM_WIDTH{1'b1}} << (3'(WORD_BITS_LOG) - lg));
    if (r_reg.width == '0 || r_reg.height == '0) begin
      dim_ok = 1'b0;
    end
    if ((line_dim & align_mask) != '0) begin
      dim_ok = 1'b0;
    end

    // software writes; setup is frozen while a run is in progress
    if (sw_req.wr) begin
      case (sw_req.addr)
        SW_CTRL: begin
          if (sw_req.wdata[GO_BIT] && !r_reg.busy) begin
            if (lg_ok && dim_ok) begin
              r_next.busy = 1'b1;
              r_next.done = 1'b0;
              r_next.err = 1'b0;
              r_next.bpp_log = lg;
              // stride from width, or height when at 270
              if (r_reg.ori == ORI_270) begin
                r_next.stride = STRIDE_BITS'(bytes_of(r_reg.height, lg));
              end else begin
                r_next.stride = STRIDE_BITS'(bytes_of(r_reg.width, lg));
              end
              r_next.mul_a = r_reg.upper;
              r_next.mul_go = 1'b1;
              r_next.st = ST_MUL_CORNER;
            end else begin
              r_next.err = 1'b1;
            end
          end
        end
        SW_PANEL: begin
          if (!r_reg.busy) begin
            r_next.width = sw_req.wdata[DIM_WIDTH-1:0];
            r_next.height = sw_req.wdata[HI_LSB +: DIM_WIDTH];
          end
        end
        SW_FORMAT: begin
          if (!r_reg.busy) begin
            r_next.bpp = sw_req.wdata[BPP_W-1:0];
            r_next.ori = ori_t'(sw_req.wdata[ORI_LSB +: 2]);
          end
        end
        SW_CORNER: begin
          if (!r_reg.busy) begin
            r_next.left = sw_req.wdata[DIM_WIDTH-1:0];
            r_next.upper = sw_req.wdata[HI_LSB +: DIM_WIDTH];
          end
        end
        SW_STATUS: begin
          // sticky flags clear on a one; a flag set this cycle wins below
          if (sw_req.wdata[DONE_BIT]) begin
            r_next.done = 1'b0;
          end
          if (sw_req.wdata[ERR_BIT]) begin
            r_next.err = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // software reads, answered one cycle later; holes read as zero
    if (sw_req.rd) begin
      case (sw_req.addr)
        SW_PANEL: r_next.rdata = {6'h0, r_reg.height, 6'h0, r_reg.width};
        SW_FORMAT: r_next.rdata = {14'h0, r_reg.ori, 11'h0, r_reg.bpp};
        SW_CORNER: r_next.rdata = {6'h0, r_reg.upper, 6'h0, r_reg.left};
        SW_STATUS: r_next.rdata = {29'h0, r_reg.err, r_reg.done, r_reg.busy};
        SW_START_RES: r_next.rdata = {16'h0, r_reg.start_addr};
        SW_STRIDE_RES: r_next.rdata = {22'h0, r_reg.line_words};
        default: r_next.rdata = RESET_WORD;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    case (r_reg.st)
      ST_IDLE: ;
      ST_MUL_CORNER: begin
        if (mul_done) begin
          // corner = upper * stride + left / bpp
          r_next.corner = MATH_W'(mul_p) + (MATH_W'(r_reg.left) >> r_reg.bpp_log);
          // second product: rows below for 180, columns for 270
          if (r_reg.ori == ORI_180) begin
            r_next.mul_a = r_reg.height - DIM_WIDTH'(1);
          end else begin
            r_next.mul_a = r_reg.width - DIM_WIDTH'(1);
          end
          r_next.mul_go = 1'b1;
          r_next.st = ST_MUL_FAR;
        end
      end
      ST_MUL_FAR: begin
        if (mul_done) begin
          r_next.far = MATH_W'(mul_p);
          r_next.st = ST_CALC;
        end
      end
      ST_CALC: begin
        hb = bytes_of(r_reg.height, r_reg.bpp_log);
        wb = bytes_of(r_reg.width, r_reg.bpp_log);
        // every division below is a right shift, so fractions drop
        case (r_reg.ori)
          ORI_0: sum = r_reg.corner >> 2;
          ORI_90: sum = ((r_reg.corner + hb + pad_of(hb)) >> 2) - ONE;
          ORI_180: sum = ((r_reg.corner + r_reg.far + wb + pad_of(wb)) >> 2) - ONE;
          ORI_270: sum = (r_reg.corner + r_reg.far) >> 2;
          default: sum = '0;
        endcase
        // words per line from width or height
        // the line dimension was checked for whole words at go
        if (r_reg.ori == ORI_0 || r_reg.ori == ORI_180) begin
          line_pix = r_reg.width;
        end else begin
          line_pix = r_reg.height;
        end
        // start field is 16 bits wide; higher bits cannot reach the device
        r_next.start_addr = sum[START_W-1:0];
        r_next.line_words =
          STRIDE_W'(line_pix >> (3'(WORD_BITS_LOG) - r_reg.bpp_log));
        // orientation and depth into the settings word
        r_next.dev.valid = 1'b1;
        r_next.dev.addr = DEV_SETTINGS;
        r_next.dev.wdata = {14'h0, r_reg.ori, 11'h0, r_reg.bpp};
        r_next.st = ST_WR_SET;
      end
      ST_WR_SET: begin
        if (dev_ready) begin
          // word address of the first fetched word
          r_next.dev.addr = DEV_START;
          r_next.dev.wdata = {16'h0, r_reg.start_addr};
          r_next.st = ST_WR_START;
        end
      end
      ST_WR_START: begin
        if (dev_ready) begin
          r_next.dev.addr = DEV_STRIDE;
          r_next.dev.wdata = {22'h0, r_reg.line_words};
          r_next.st = ST_WR_OFS;
        end
      end
      ST_WR_OFS: begin
        if (dev_ready) begin
          r_next.dev = '0;
          r_next.busy = 1'b0;
          r_next.done = 1'b1;
          r_next.st = ST_IDLE;
        end
      end
      default: begin
        r_next.st = ST_IDLE;
        r_next.busy = 1'b0;
        r_next.dev = '0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sw_rdata = r_reg.rdata;
  assign dev_req = r_reg.dev;

endmodule

// File: tb/frame_addr_ctrl_monitor.sv
// port checker for the frame address controller
// assumes one clock domain and a bind from the bench top
module frame_addr_ctrl_monitor import frame_addr_pkg::*; #(
  parameter int DIM_WIDTH = DIM_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // software port
  input wire sw_req_t sw_req,
  input wire logic [31:0] sw_rdata,
  // device port
  input wire dev_req_t dev_req,
  input wire logic dev_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire acc = dev_req.valid && dev_ready;
  wire [7:0] da = dev_req.addr;
  ////////////////////////////////////////////////////////////////////////////
  a_req_holds: assert property (
    dev_req.valid && !dev_ready |=> dev_req.valid && $stable(dev_req.wdata) && $stable(da))
    else $error("device request moved before accept");
  a_first_settings: assert property (
    $rose(dev_req.valid) |-> da == DEV_SETTINGS) else $error("sequence not opened by settings");
  a_start_follows: assert property (
    acc && da == DEV_SETTINGS |=> dev_req.valid && da == DEV_START)
    else $error("start word not next");
  a_stride_follows: assert property (
    acc && da == DEV_START |=> dev_req.valid && da == DEV_STRIDE)
    else $error("stride word not next");
  a_stride_last: assert property (
    acc && da == DEV_STRIDE |=> !dev_req.valid) else $error("write after stride");
  a_settings_fmt: assert property (
    dev_req.valid && da == DEV_SETTINGS |-> dev_req.wdata[31:18] == 14'h0000 &&
    dev_req.wdata[15:5] == 11'h000) else $error("settings word has stray bits");
  a_bpp_legal: assert property (
    dev_req.valid && da == DEV_SETTINGS |->
    dev_req.wdata[4:0] inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10}) else $error("bad depth");
  a_start_width: assert property (
    dev_req.valid && da == DEV_START |-> dev_req.wdata[31:16] == 16'h0000)
    else $error("start word too wide");
  a_stride_width: assert property (
    dev_req.valid && da == DEV_STRIDE |-> dev_req.wdata[31:10] == 22'h00_0000)
    else $error("stride too wide");
endmodule

// File: tb/display_dev_model.sv
// behavioural model of the display device register port
// assumes word writes held until ready; slow stalls ready three cycles of four
module display_dev_model import frame_addr_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire dev_req_t dev_req,
  input wire logic slow,
  output logic dev_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] display_settings_reg;
  logic [31:0] main_start_word_address_reg;
  logic [31:0] main_line_word_stride_reg;
  logic [1:0] stall_reg;
  int n_writes;
  assign dev_ready = !slow || stall_reg == 2'h2;
  wire [1:0] orientation = display_settings_reg[17:16];
  wire [31:0] second_line_word = main_start_word_address_reg + main_line_word_stride_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      display_settings_reg <= 32'h0000_0000;
      main_start_word_address_reg <= 32'h0000_0000;
      main_line_word_stride_reg <= 32'h0000_0000;
      stall_reg <= 2'h0;
      n_writes <= 0;
    end else begin
      stall_reg <= stall_reg + 2'h1;
      if (dev_req.valid && dev_ready) begin
        n_writes <= n_writes + 1;
        case (dev_req.addr)
          DEV_SETTINGS: display_settings_reg <= dev_req.wdata;
          DEV_START: main_start_word_address_reg <= {16'h0000, dev_req.wdata[15:0]};
          DEV_STRIDE: main_line_word_stride_reg <= {22'h00_0000, dev_req.wdata[9:0]};
          default: ;
        endcase
      end
    end
  end
endmodule

// File: tb/rotated_frame_address_setup_bench.sv
// self-checking bench for the frame address controller
// assumes the device model and checker are compiled first
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module rotated_frame_address_setup_bench import frame_addr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  sw_req_t req = '0;
  logic [31:0] rdata;
  dev_req_t dreq;
  logic ready;
  logic [31:0] rd;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #20 clk = ~clk;
  frame_addr_ctrl #(.DIM_WIDTH(DIM_W)) DUT (.clk(clk), .rst(rst), .sw_req(req),
    .sw_rdata(rdata), .dev_req(dreq), .dev_ready(ready));
  display_dev_model DEV (.clk(clk), .rst(rst), .dev_req(dreq), .slow(slow), .dev_ready(ready));
  ////////////////////////////////////////////////////////////////////////////
  task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) req <= '0;
  endtask
  task automatic sw_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge clk) req <= '0;
    #1 d = rdata;
  endtask
  task automatic wait_bit(input int b);
    for (int i = 0; i < 100; i++) begin
      sw_rd(SW_STATUS, rd);
      if (rd[b] === 1'b1) break;
    end
  endtask
  function automatic logic [31:0] exp_start(int o, int w, int h, int b, int l, int u);
    int s;
    int c;
    int r;
    s = (o == 3) ? h * b / 8 : w * b / 8;
    c = u * s + l / b;
    case (o)
      0: r = c / 4;
      1: r = (c + h * b / 8 + ((4 - h * b / 8) & 3)) / 4 - 1;
      2: r = (c + s * (h - 1) + w * b / 8 + ((4 - w * b / 8) & 3)) / 4 - 1;
      default: r = (c + (w - 1) * s) / 4;
    endcase
    return 32'(r) & 32'h0000_ffff;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic check_reset;
    logic [7:0] regs [5] = '{SW_PANEL, SW_FORMAT, SW_CORNER, SW_STATUS, 8'h1C};
    foreach (regs[i]) begin
      sw_rd(regs[i], rd);
      `CHK("own reg at reset", 32'h0000_0000, rd)
    end
    `CHK("device start at reset", 32'h0000_0000, DEV.main_start_word_address_reg)
  endtask
  // sizes keep the line dimension (width, or height at 90/270) a multiple of 32 over depth, as software must
  task automatic run(input int o, input int w, input int h, input int b, input int l,
                     input int u, input logic s);
    logic [31:0] e;
    logic [31:0] k;
    logic [31:0] pan;
    pan = {6'h00, h[9:0], 6'h00, w[9:0]};
    @(posedge clk) slow <= s;
    sw_wr(SW_PANEL, pan);
    sw_wr(SW_FORMAT, {14'h0000, o[1:0], 11'h000, b[4:0]});
    sw_wr(SW_CORNER, {6'h00, u[9:0], 6'h00, l[9:0]});
    sw_wr(SW_CTRL, 32'h0000_0001);
    sw_wr(SW_PANEL, 32'h0000_0000);
    wait_bit(DONE_BIT);
    e = exp_start(o, w, h, b, l, u);
    k = 32'((o[0] ? h : w) * b / 32);
    `CHK("done flag", 1'b1, rd[DONE_BIT])
    `CHK("busy clear", 1'b0, rd[BUSY_BIT])
    `CHK("settings", {14'h0000, o[1:0], 11'h000, b[4:0]}, DEV.display_settings_reg)
    `CHK("mode field", o[1:0], DEV.orientation)
    `CHK("start", e, DEV.main_start_word_address_reg)
    `CHK("stride", k, DEV.main_line_word_stride_reg)
    `CHK("second line word", e + k, DEV.second_line_word)
    sw_rd(SW_START_RES, rd);
    `CHK("start readback", e, rd)
    sw_rd(SW_STRIDE_RES, rd);
    `CHK("stride readback", k, rd)
    sw_rd(SW_CORNER, rd);
    `CHK("corner readback", {6'h00, u[9:0], 6'h00, l[9:0]}, rd)
    sw_rd(SW_PANEL, rd);
    `CHK("panel kept while busy", pan, rd)
    sw_wr(SW_STATUS, 32'h0000_0006);
  endtask
  task automatic check_bad_bpp;
    int n;
    n = DEV.n_writes;
    sw_wr(SW_FORMAT, 32'h0000_0003);
    sw_wr(SW_CTRL, 32'h0000_0001);
    wait_bit(ERR_BIT);
    `CHK("error flag", 1'b1, rd[ERR_BIT])
    `CHK("no device writes", n, DEV.n_writes)
  endtask
  // a quarter-turn height of 238 at 4 bpp leaves part of a word per line
  task automatic check_bad_dim;
    int n;
    n = DEV.n_writes;
    sw_wr(SW_STATUS, 32'h0000_0006);
    sw_wr(SW_PANEL, 32'h00EE_0140);
    sw_wr(SW_FORMAT, 32'h0001_0004);
    sw_wr(SW_CTRL, 32'h0000_0001);
    wait_bit(ERR_BIT);
    `CHK("size error flag", 1'b1, rd[ERR_BIT])
    `CHK("no writes on bad size", n, DEV.n_writes)
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    check_reset;
    for (int i = 0; i < 4; i++) begin
      run(i, 320, 240, 4, 0, 0, i[0]);
    end
    run(2, 320, 240, 1, 41, 2, 1'b1);
    run(1, 320, 240, 2, 41, 2, 1'b0);
    run(3, 320, 240, 8, 41, 2, 1'b1);
    run(0, 320, 240, 16, 41, 2, 1'b0);
    check_bad_bpp;
    check_bad_dim;
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end
endmodule
bind frame_addr_ctrl frame_addr_ctrl_monitor #(.DIM_WIDTH(DIM_WIDTH)) u_mon (.clk(clk),
  .rst(rst), .sw_req(sw_req), .sw_rdata(sw_rdata), .dev_req(dev_req), .dev_ready(dev_ready));
